/* core/acs_pkg.sv */
package acs_pkg;

   // core clock and derived timing
   localparam int  CLK_FREQ_MHZ     = 200;
   localparam real POR_TIME_MS      = 0.5;
   localparam int  POR_CYCLES       = $rtoi(POR_TIME_MS * 1000.0 * CLK_FREQ_MHZ);

   // serial word
   localparam int  WORD_BITS        = 32;
   localparam int  BIT_CNT_W        = 5;
   localparam int  SEQ_CNT_W        = 20;

   // conversion timing: two calibration slots, then the measurement
   localparam int  CAL_CYCLES       = 16;
   localparam int  CONV_BASE_CYCLES = 64;
   localparam int  OSR_CODE_MAX     = 9;
   localparam int  SCK_HALF_CYCLES  = 4;

   // configuration word shifted in on the data input, first bit is bit 31
   localparam int  CFG_EN_POS       = 31;
   localparam int  CFG_CHP_POS      = 28;
   localparam int  CFG_CHN_POS      = 25;
   localparam int  CFG_REF_POS      = 22;
   localparam int  CFG_OSR_POS      = 18;
   localparam int  CFG_TWOX_POS     = 17;

   // serial clock source select levels
   localparam logic SCK_SRC_HOST    = 1'b0;
   localparam logic SCK_SRC_DEVICE  = 1'b1;

   typedef enum logic [1:0] {ST_POR, ST_CONV, ST_SLEEP, ST_OUT} acs_state_t;
   typedef enum logic [1:0] {CAL_OFFSET, CAL_FULLSCALE, CAL_MEASURE} acs_cal_t;

   typedef struct packed {
      logic [2:0] ch_pos;
      logic [2:0] ch_neg;
      logic [2:0] ref_sel;
      logic [3:0] osr;
      logic       twox;
   } acs_cfg_t;

   // input_channel_zero positive, input_channel_one negative, reference_pair_first, osr 256, 1x
   localparam acs_cfg_t CFG_RESET = '{ch_pos: 3'h0, ch_neg: 3'h1, ref_sel: 3'h0, osr: 4'h2, twox: 1'b0};

   typedef struct packed {
      logic        over;
      logic        under;
      logic        sign;
      logic [28:0] code;
   } acs_fe_t;

   localparam logic [31:0] WORD_RESET = 32'h0;
   localparam logic [31:0] WORD_OVER  = 32'h30000000;
   localparam logic [31:0] WORD_UNDER = 32'h0fffffff;

endpackage

/* core/acs_link.sv */
`timescale 1ns/10ps
`default_nettype none
// serial-clock side: counts falling edges, shifts data out and config in
module acs_link
   import acs_pkg::*;
(
   // link clock and reset
   input  wire logic        sck,
   input  wire logic        link_rst,
   // pins
   input  wire logic        sdi,
   output logic             sdo_bit,
   // core side
   input  wire logic [31:0] word,
   output logic [31:0]      cfg_word,
   output logic             done_tgl
);
   logic [31:0]          sdi_sr_q;
   logic [BIT_CNT_W-1:0] cnt_q, cnt_d;
   logic                 bit_q, bit_d;
   logic [31:0]          hold_q, hold_d;
   logic                 tgl_q, tgl_d;

   always_ff @(posedge sck or posedge link_rst) begin
      if (link_rst) begin
         sdi_sr_q <= WORD_RESET;
      end else begin
         sdi_sr_q <= {sdi_sr_q[30:0], sdi};
      end
   end

   // word is static in the core for the whole transfer, so no resampling is needed
   always_comb begin
      cnt_d  = cnt_q + 1'b1;
      bit_d  = word[5'd30 - cnt_q];
      hold_d = hold_q;
      tgl_d  = tgl_q;
      if (cnt_q == 5'd31) begin
         hold_d = sdi_sr_q;
         tgl_d  = ~tgl_q;
      end
   end

   always_ff @(negedge sck or posedge link_rst) begin
      if (link_rst) begin
         cnt_q  <= '0;
         bit_q  <= 1'b0;
         hold_q <= WORD_RESET;
         tgl_q  <= 1'b0;
      end else begin
         cnt_q  <= cnt_d;
         bit_q  <= bit_d;
         hold_q <= hold_d;
         tgl_q  <= tgl_d;
      end
   end

   assign sdo_bit  = bit_q;
   assign cfg_word = hold_q;
   assign done_tgl = tgl_q;

endmodule
`default_nettype wire

/* core/acs_sequencer.sv */
`timescale 1ns/10ps
`default_nettype none
module acs_sequencer
   import acs_pkg::*;
#(
   parameter int POR_LEN = acs_pkg::POR_CYCLES
)
(
   // core clock and reset
   input  wire logic              clock,
   input  wire logic              reset,
   // supply monitor
   input  wire logic              supply_ok,
   // serial port pins
   input  wire logic              cs_n,
   input  wire logic              sck_source_select,
   input  wire logic              sck_in,
   output logic                   sck_out,
   output logic                   sck_oe,
   input  wire logic              sdi,
   output logic                   sdo_out,
   output logic                   sdo_oe,
   output logic                   busy,
   // converter front end
   input  wire acs_pkg::acs_fe_t  fe,
   output acs_pkg::acs_cfg_t      conv_cfg,
   output acs_pkg::acs_cal_t      cal_phase
);
   import acs_pkg::*;

   logic [1:0]           cs_sync_q, ext_sync_q, sup_sync_q, tgl_sync_q;
   logic                 cs_s, ext_s, sup_s, tgl_seen_q, done_evt;
   acs_state_t           st_q, st_d;
   logic [SEQ_CNT_W-1:0] cnt_q, cnt_d;
   acs_cfg_t             cfg_q, cfg_d;
   logic [31:0]          res_q, res_d, prev_q, prev_d;
   logic                 busy_q, busy_d;
   logic                 sck_q, sck_d;
   logic [2:0]           div_q, div_d;
   logic [5:0]           fall_q, fall_d;
   logic                 link_rst, link_bit, link_tgl;
   logic [31:0]          link_cfg, out_word;

   function automatic logic [SEQ_CNT_W-1:0] conv_len(input logic [3:0] osr);
      logic [3:0] eff;
      eff = (osr > 4'(OSR_CODE_MAX)) ? 4'(OSR_CODE_MAX) : osr;
      return SEQ_CNT_W'(2 * CAL_CYCLES) + (SEQ_CNT_W'(CONV_BASE_CYCLES) << eff);
   endfunction

   function automatic logic [31:0] build_word(input acs_fe_t f);
      if (f.over) begin
         return WORD_OVER;
      end else if (f.under) begin
         return WORD_UNDER;
      end
      return {2'b00, f.sign, f.code};
   endfunction

   // pins cross two flops before use; the done toggle comes from the link clock
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         cs_sync_q  <= 2'b11;
         ext_sync_q <= 2'b00;
         sup_sync_q <= 2'b00;
         tgl_sync_q <= 2'b00;
         tgl_seen_q <= 1'b0;
      end else begin
         cs_sync_q  <= {cs_sync_q[0], cs_n};
         ext_sync_q <= {ext_sync_q[0], sck_source_select};
         sup_sync_q <= {sup_sync_q[0], supply_ok};
         tgl_sync_q <= {tgl_sync_q[0], link_tgl};
         tgl_seen_q <= tgl_sync_q[1];
      end
   end

   assign cs_s     = cs_sync_q[1];
   assign ext_s    = ext_sync_q[1];
   assign sup_s    = sup_sync_q[1];
   // link reset drops the toggle back to zero; that extra edge lands in conversion, where it is ignored
   assign done_evt = tgl_sync_q[1] ^ tgl_seen_q;

   // link logic is reset whenever chip select is high, which restarts the bit count
   assign link_rst = reset | cs_s;
   // 2x mode adds one conversion of latency; conversion length does not depend on twox
   assign out_word = cfg_q.twox ? prev_q : res_q;

   acs_link u_link (
      .sck      (sck_in),
      .link_rst (link_rst),
      .sdi      (sdi),
      .sdo_bit  (link_bit),
      .word     (out_word),
      .cfg_word (link_cfg),
      .done_tgl (link_tgl)
   );

   always_comb begin
      st_d   = st_q;
      cnt_d  = cnt_q;
      cfg_d  = cfg_q;
      res_d  = res_q;
      prev_d = prev_q;
      busy_d = busy_q;
      if (!sup_s) begin
         st_d   = ST_POR;
         cnt_d  = '0;
         cfg_d  = CFG_RESET;
         res_d  = WORD_RESET;
         prev_d = WORD_RESET;
         busy_d = 1'b1;
      end else begin
         unique case (st_q)
            ST_POR: begin
               if (cnt_q == SEQ_CNT_W'(POR_LEN - 1)) begin
                  st_d  = ST_CONV;
                  cnt_d = '0;
               end else begin
                  cnt_d = cnt_q + 1'b1;
               end
            end
            ST_CONV: begin
               if (cnt_q == conv_len(cfg_q.osr) - 1'b1) begin
                  st_d   = ST_SLEEP;
                  res_d  = build_word(fe);
                  prev_d = res_q;
                  busy_d = 1'b0;
               end else begin
                  cnt_d = cnt_q + 1'b1;
               end
            end
            ST_SLEEP: begin
               if (!cs_s) begin
                  st_d = ST_OUT;
               end
            end
            ST_OUT: begin
               if (done_evt || cs_s) begin
                  st_d   = ST_CONV;
                  cnt_d  = '0;
                  busy_d = 1'b1;
                  if (done_evt && link_cfg[CFG_EN_POS]) begin
                     cfg_d.ch_pos  = link_cfg[CFG_CHP_POS+:3];
                     cfg_d.ch_neg  = link_cfg[CFG_CHN_POS+:3];
                     cfg_d.ref_sel = link_cfg[CFG_REF_POS+:3];
                     cfg_d.osr     = link_cfg[CFG_OSR_POS+:4];
                     cfg_d.twox    = link_cfg[CFG_TWOX_POS];
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         st_q   <= ST_POR;
         cnt_q  <= '0;
         cfg_q  <= CFG_RESET;
         res_q  <= WORD_RESET;
         prev_q <= WORD_RESET;
         busy_q <= 1'b1;
      end else begin
         st_q   <= st_d;
         cnt_q  <= cnt_d;
         cfg_q  <= cfg_d;
         res_q  <= res_d;
         prev_q <= prev_d;
         busy_q <= busy_d;
      end
   end

   // internal serial clock: exactly 32 low-going edges per read, idles low
   always_comb begin
      sck_d  = 1'b0;
      div_d  = '0;
      fall_d = '0;
      if (st_q == ST_OUT && ext_s == SCK_SRC_DEVICE && fall_q < 6'd32) begin
         fall_d = fall_q;
         if (div_q == 3'(SCK_HALF_CYCLES - 1)) begin
            sck_d = ~sck_q;
            if (sck_q) begin
               fall_d = fall_q + 1'b1;
            end
         end else begin
            sck_d = sck_q;
            div_d = div_q + 1'b1;
         end
      end else if (st_q == ST_OUT) begin
         fall_d = fall_q;
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         sck_q  <= 1'b0;
         div_q  <= '0;
         fall_q <= '0;
      end else begin
         sck_q  <= sck_d;
         div_q  <= div_d;
         fall_q <= fall_d;
      end
   end

   assign sck_out   = sck_q;
   assign sck_oe    = (ext_s == SCK_SRC_DEVICE);
   assign sdo_out   = (st_q == ST_OUT) ? link_bit : busy_q;
   assign sdo_oe    = !cs_s;
   assign busy      = busy_q;
   assign conv_cfg  = cfg_q;
   assign cal_phase = (st_q != ST_CONV)                     ? CAL_MEASURE :
                      (cnt_q < SEQ_CNT_W'(CAL_CYCLES))      ? CAL_OFFSET :
                      (cnt_q < SEQ_CNT_W'(2 * CAL_CYCLES))  ? CAL_FULLSCALE : CAL_MEASURE;

   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   a_sleep_after_conv: assert property (
      $changed(st_q) && st_q == ST_SLEEP |-> $past(st_q) == ST_CONV)
      else $error("sleep entered from a state other than conversion");
   a_sleep_holds_high: assert property (
      st_q == ST_SLEEP && cs_s && sup_s |=> st_q == ST_SLEEP)
      else $error("left sleep while chip select high");
   a_result_static: assert property (
      st_q == ST_SLEEP ##1 st_q inside {ST_SLEEP, ST_OUT} |-> $stable(res_q))
      else $error("result changed while held");
   a_out_on_select: assert property (
      st_q == ST_SLEEP && !cs_s && sup_s |=> st_q == ST_OUT ##0 sdo_oe)
      else $error("chip select low did not start output");
   a_abort_restart: assert property (
      st_q == ST_OUT && cs_s && sup_s |=> st_q == ST_CONV && busy_q && cnt_q == '0)
      else $error("abort did not restart conversion");
   a_status_line: assert property (
      st_q != ST_OUT |-> sdo_out == busy_q ##0 (st_q != ST_CONV || busy_q))
      else $error("status line wrong outside output");
   a_por_defaults: assert property (
      $past(st_q) == ST_POR && st_q == ST_CONV |-> cfg_q == CFG_RESET)
      else $error("first conversion not on reset settings");
   a_brownout_reset: assert property (
      !sup_s |=> st_q == ST_POR && cfg_q == CFG_RESET && busy_q)
      else $error("low supply did not force reset state");
   a_cfg_between: assert property (
      st_q inside {ST_CONV, ST_SLEEP} && $past(st_q) == st_q && sup_s |-> $stable(cfg_q))
      else $error("settings changed inside a conversion");
   a_cal_slots: assert property (
      st_q == ST_CONV && cnt_q == '0 |-> cal_phase == CAL_OFFSET
         ##16 (st_q != ST_CONV || cal_phase == CAL_FULLSCALE))
      else $error("calibration slot misplaced");
   a_sck_count: assert property (
      fall_q == 6'd32 |=> !sck_q)
      else $error("internal clock ran past 32 falls");
   a_sck_quiet: assert property (
      st_q != ST_OUT |=> !sck_q)
      else $error("internal clock moved outside data output");
   a_por_length: assert property (
      st_q == ST_POR && cnt_q != SEQ_CNT_W'(POR_LEN - 1) |=> st_q == ST_POR)
      else $error("power-on reset ended early");
   // the front end word is taken on the last cycle of the conversion
   a_over_code: assert property (
      st_q == ST_CONV && sup_s && fe.over && cnt_q == conv_len(cfg_q.osr) - 1'b1 |=> res_q == WORD_OVER)
      else $error("overrange code not stored");
   a_under_code: assert property (
      st_q == ST_CONV && sup_s && !fe.over && fe.under && cnt_q == conv_len(cfg_q.osr) - 1'b1
         |=> res_q == WORD_UNDER)
      else $error("underrange code not stored");
   a_word_done: assert property (
      st_q == ST_OUT && done_evt && sup_s |=> st_q == ST_CONV && busy_q && cnt_q == '0)
      else $error("full word did not restart conversion");
   a_abort_keeps_cfg: assert property (
      st_q == ST_OUT && cs_s && !done_evt && sup_s |=> $stable(cfg_q))
      else $error("aborted transfer changed settings");
   a_busy_sleep: assert property (
      st_q inside {ST_SLEEP, ST_OUT} |-> !busy_q)
      else $error("busy high after conversion finished");

   c_full_read:  cover property (st_q == ST_OUT && done_evt);
   c_abort_read: cover property (st_q == ST_OUT && cs_s && !done_evt);
   c_por_exit:   cover property ($past(st_q) == ST_POR && st_q == ST_CONV);
   c_cfg_update: cover property (st_q == ST_CONV && $changed(cfg_q));
   c_twox_read:  cover property (st_q == ST_OUT && cfg_q.twox);

endmodule
`default_nettype wire

/* testbench/acs_host.sv */
`timescale 1ns/10ps
`default_nettype none
module acs_host (
   // pins toward the device
   output logic        cs_n,
   output logic        sck,
   output logic        sdi,
   input  wire logic   sdo,
   input  wire logic   sck_pin,
   input  wire logic   dev_clk,
   // last 32 bits received, shifted in bit by bit, so a short frame leaves a mixed word
   output logic [31:0] rx
);
   event got;
   initial begin
      cs_n = 1'b1;
      sck = 1'b0;
      sdi = 1'b0;
      rx = 32'h0;
   end
   // selecting alone shows the conversion status on the data line
   task sel();
      cs_n = 1'b0;
      #50;
   endtask
   // fewer than 32 bits aborts the frame by raising chip select
   task xfer(input logic [31:0] cfg, input int nbits);
      int i;
      sdi = cfg[31];
      cs_n = 1'b0;
      if (!dev_clk)
         #50;
      for (i = 0; i < nbits; i++) begin
         if (dev_clk)
            @(posedge sck_pin);
         else
            #62.5 sck = 1'b1;
         rx = {rx[30:0], sdo};
         if (dev_clk)
            @(negedge sck_pin);
         else
            #62.5 sck = 1'b0;
         sdi = (i < 31) ? cfg[30 - i] : 1'b0;
      end
      // released data input must not keep its last level
      sdi = ~sdi;
      #50;
      cs_n = 1'b1;
      if (nbits == 32)
         -> got;
   endtask
endmodule
`default_nettype wire

/* testbench/tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
   import acs_pkg::*;
   localparam int POR_SIM = 20;
   logic        clock;
   logic        reset;
   logic        supply_ok;
   logic        sck_source_select;
   logic        cs_n;
   logic        host_sck;
   logic        sdi;
   logic        sck_out;
   logic        sck_oe;
   logic        sdo_out;
   logic        sdo_oe;
   logic        busy;
   logic        tgl = 1'b0;
   wire logic   sck_w;
   wire logic   sdo_w;
   logic [31:0] rx;
   acs_fe_t     fe;
   acs_cfg_t    conv_cfg;
   acs_cal_t    cal_phase;
   acs_cfg_t    cur;
   acs_cfg_t    nxt;
   logic [31:0] last_w;
   logic [31:0] exp_q[$];
   int          n_errors = 0;
   int          check_count = 0;

   assign sck_w = sck_oe ? sck_out : host_sck;
   // a released data line shows a moving pattern, never a held level
   assign sdo_w = sdo_oe ? sdo_out : tgl;
   always @(posedge clock) tgl <= ~tgl;

   acs_sequencer #(.POR_LEN(POR_SIM)) u_dut (
      .clock(clock), .reset(reset), .supply_ok(supply_ok), .cs_n(cs_n),
      .sck_source_select(sck_source_select), .sck_in(sck_w), .sck_out(sck_out),
      .sck_oe(sck_oe), .sdi(sdi), .sdo_out(sdo_out), .sdo_oe(sdo_oe), .busy(busy),
      .fe(fe), .conv_cfg(conv_cfg), .cal_phase(cal_phase));
   acs_host u_host (
      .cs_n(cs_n), .sck(host_sck), .sdi(sdi), .sdo(sdo_w), .sck_pin(sck_w),
      .dev_clk(sck_source_select), .rx(rx));

   function automatic logic [31:0] exp_word(acs_fe_t f);
      if (f.over)
         return WORD_OVER;
      if (f.under)
         return WORD_UNDER;
      return {2'b00, f.sign, f.code};
   endfunction
   function automatic logic [31:0] cfg_word(logic en, acs_cfg_t c);
      return {en, c.ch_pos, c.ch_neg, c.ref_sel, c.osr, c.twox, 17'h0};
   endfunction

   task chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task close_out();
      if (n_errors == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task wait_busy(input logic v);
      int k;
      k = 0;
      while (busy !== v && k < 40000) begin
         @(negedge clock);
         k++;
      end
      if (busy !== v) begin
         n_errors++;
         close_out();
      end
   endtask

   // one conversion and readout; i picks the awkward case
   task run(input int i);
      logic    en;
      acs_fe_t f;
      en = (i != 3);
      f.over = (i == 1);
      f.under = (i == 3);
      f.sign = 1'($urandom());
      f.code = 29'($urandom());
      nxt.ch_pos = 3'($urandom());
      nxt.ch_neg = 3'($urandom());
      nxt.ref_sel = 3'($urandom());
      nxt.osr = 4'($urandom_range(1, 0));
      nxt.twox = (i == 4);
      @(posedge clock);
      fe <= f;
      sck_source_select <= (i == 4);
      if (i == 1) begin
         u_host.sel();
         @(negedge clock);
         chk(sdo_w, 1'b1);
      end
      wait_busy(1'b0);
      if (i == 1)
         chk(sdo_w, 1'b0);
      chk(sck_oe, i == 4);
      if (i == 0) begin
         @(posedge clock);
         fe <= ~f;
         repeat (200) @(negedge clock);
         chk(busy, 1'b0);
         chk(sdo_oe, 1'b0);
      end
      // 2x mode hands out the word of the conversion before
      if (i != 2)
         exp_q.push_back(cur.twox ? last_w : exp_word(f));
      last_w = exp_word(f);
      u_host.xfer(cfg_word(en, nxt), (i == 2) ? 10 : 32);
      repeat (6) @(negedge clock);
      chk(busy, 1'b1);
      chk(32'(cal_phase), 32'(CAL_OFFSET));
      if (en && i != 2)
         cur = nxt;
      chk({18'h0, conv_cfg}, {18'h0, cur});
   endtask

   always @(u_host.got) begin : mon
      logic [31:0] e;
      e = (exp_q.size() > 0) ? exp_q.pop_front() : ~rx;
      chk(rx, e);
   end

   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   // the whole run takes some 6,000 cycles
   initial begin
      #400000;
      n_errors++;
      close_out();
   end

   initial begin
      void'($urandom(32'had5c5e7f));
      reset = 1'b1;
      supply_ok = 1'b1;
      sck_source_select = 1'b0;
      fe = '0;
      cur = CFG_RESET;
      last_w = WORD_RESET;
      repeat (12) @(posedge clock);
      reset <= 1'b0;
      @(negedge clock);
      chk({18'h0, conv_cfg}, {18'h0, CFG_RESET});
      // supply is seen two clocks after release, then the power-on count runs
      repeat (POR_SIM) @(negedge clock);
      chk(32'(cal_phase), 32'(CAL_MEASURE));
      repeat (4) @(negedge clock);
      chk(32'(cal_phase), 32'(CAL_OFFSET));
      repeat (276) @(negedge clock);
      chk(busy, 1'b1);
      for (int i = 0; i < 6; i++)
         run(i);
      @(posedge clock);
      supply_ok <= 1'b0;
      repeat (6) @(negedge clock);
      chk(busy, 1'b1);
      chk({18'h0, conv_cfg}, {18'h0, CFG_RESET});
      cur = CFG_RESET;
      last_w = WORD_RESET;
      @(posedge clock);
      supply_ok <= 1'b1;
      run(5);
      chk(exp_q.size(), 32'h0);
      close_out();
   end
endmodule
`default_nettype wire
